// *** stx_pkg.sv ***
// stx_pkg: constants, register map and types for the transmit input port
// assumes: one clock domain (mclk), AXI4-Lite register access
package stx_pkg;
	localparam int CHAR_W    = 8;
	localparam int CTRL_W    = 2;
	localparam int SYM_W     = 10;
	localparam int AXI_AW    = 8;
	localparam int AXI_DW    = 32;
	localparam int PASS_NORM = 511;
	localparam int PASS_LONG = 527;
	localparam int CNT_W     = 10;
	// register byte addresses
	localparam logic [AXI_AW-1:0] CFG_ADDR  = 8'h00;
	localparam logic [AXI_AW-1:0] STAT_ADDR = 8'h04;
	localparam logic [AXI_AW-1:0] IRQS_ADDR = 8'h08;
	localparam logic [AXI_AW-1:0] IMSK_ADDR = 8'h0c;
	localparam logic [AXI_AW-1:0] CMD_ADDR  = 8'h10;
	localparam logic [AXI_AW-1:0] LAST_ADDR = 8'h14;
	// cfg fields
	localparam int CFG_CLKSEL  = 0;
	localparam int CFG_BYPASS  = 1;
	localparam int CFG_BISTN   = 2;
	localparam int CFG_RXSEL   = 3;
	localparam int CFG_OE1     = 4;
	localparam int CFG_OE2     = 5;
	localparam int CFG_HALF    = 6;
	localparam int CFG_W       = 7;
	localparam logic [CFG_W-1:0] CFG_RST = 7'h34;
	// cmd fields (write pulses)
	localparam int CMD_RECENTRE = 0;
	localparam int CMD_SYNC     = 1;
	// irq status / mask fields
	localparam int EV_BUFERR = 0;
	localparam int EV_PASS   = 1;
	localparam int EV_NOREF  = 2;
	localparam int EV_W      = 3;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control field codes with encoder enabled
	localparam logic [1:0] CT_DATA    = 2'h0;
	localparam logic [1:0] CT_SPECIAL = 2'h1;
	localparam logic [1:0] CT_REPLACE = 2'h2;
	localparam logic [1:0] CT_ERRCHR  = 2'h3;
	typedef enum logic [2:0] {
		STX_KIND_DATA    = 3'b001,
		STX_KIND_SPECIAL = 3'b010,
		STX_KIND_REPL    = 3'b100
	} stx_kind_e;
endpackage

// *** stx_char_if.sv ***
// stx_char_if: captured character handed from capture to error/bist logic
// assumes: both ends on mclk
`timescale 1ns/1ps
interface stx_char_if;
	logic                   valid;
	logic [stx_pkg::SYM_W-1:0] sym;
	logic                   bypass;
	modport src (output valid, output sym, output bypass);
	modport dst (input valid, input sym, input bypass);
endinterface // stx_char_if

// *** stx_capture.sv ***
// stx_capture: samples character and control on the selected character clock
// assumes: clock strobes already synchronised to mclk
`timescale 1ns/1ps
module stx_capture
	import stx_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              charStb,
	input  wire logic [CHAR_W-1:0] charIn,
	input  wire logic [CTRL_W-1:0] ctrlIn,
	input  wire logic              bypass,
	stx_char_if.src                out
);
	logic             valid, next_valid;
	logic [SYM_W-1:0] sym, next_sym;
	logic             byp, next_byp;

	always_comb begin
		next_valid = charStb;
		next_sym = sym;
		next_byp = byp;
		if (charStb) begin
			// control bits on top form the raw 10-bit symbol in bypass
			next_sym = {ctrlIn, charIn};
			next_byp = bypass;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			valid <= 1'b0;
			sym <= '0;
			byp <= 1'b0;
		end else begin
			valid <= next_valid;
			sym <= next_sym;
			byp <= next_byp;
		end
	end

	assign out.valid = valid;
	assign out.sym = sym;
	assign out.bypass = byp;

	capt_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!charStb |=> $stable(sym))
		else $error("symbol changed without a capture strobe");
endmodule // stx_capture

// *** stx_tx_port.sv ***
// stx_tx_port: per-channel transmit character input port with error output
// assumes: pins are asynchronous to mclk; registers over AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module stx_tx_port
	import stx_pkg::*;
#(
	parameter int REF_TMO = 16
)(
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic [CHAR_W-1:0] txCharIn,
	input  wire logic [CTRL_W-1:0] txCtrlFieldIn,
	input  wire logic              txInputClk,
	input  wire logic              refClkIn,
	output logic                   txErrorFlag,
	output logic [SYM_W-1:0]       txSym,
	output logic [2:0]             txKind,
	output logic                   txSymValid,
	output logic                   irq,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [AXI_DW-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		return (a < LAST_ADDR) && (a[1:0] == 2'h0);
	endfunction

	stx_char_if chr();

	// pin synchronisers; first stage feeds only the second
	logic [CHAR_W-1:0] dS1, dS2;
	logic [CTRL_W-1:0] cS1, cS2;
	logic [2:0]        tS1, tS2;
	logic [2:0]        rS1, rS2;
	logic              tS3, rS3;

	// registers
	logic [CFG_W-1:0] cfg, next_cfg;
	logic [EV_W-1:0]  imsk, next_imsk;
	logic [EV_W-1:0]  irqs, next_irqs;
	logic             bufErr, next_bufErr;
	logic             syncPend, next_syncPend;
	logic             ovf, next_ovf;
	logic [CNT_W-1:0] passCnt, next_passCnt;
	logic [CNT_W-1:0] refCnt, next_refCnt;
	logic             refLost, next_refLost;
	logic             err, next_err;
	logic [SYM_W-1:0] sym, next_sym;
	logic [2:0]       kind, next_kind;
	logic             symV, next_symV;

	// axi state
	logic             awr, next_awr, wr, next_wr;
	logic [AXI_AW-1:0] awa, next_awa;
	logic [AXI_DW-1:0] wd, next_wd;
	logic [3:0]       ws, next_ws;
	logic             bv, next_bv;
	logic [1:0]       br, next_br;
	logic             rv, next_rv;
	logic [1:0]       rr, next_rr;
	logic [AXI_DW-1:0] rd, next_rd;
	logic             arr, next_arr;
	logic             awRdy, next_awRdy, wRdy, next_wRdy;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dS1 <= '0; dS2 <= '0; cS1 <= '0; cS2 <= '0;
			tS1 <= '0; tS2 <= '0; rS1 <= '0; rS2 <= '0;
			tS3 <= 1'b0; rS3 <= 1'b0;
		end else begin
			dS1 <= txCharIn; dS2 <= dS1;
			cS1 <= txCtrlFieldIn; cS2 <= cS1;
			tS1 <= {2'h0, txInputClk}; tS2 <= tS1; tS3 <= tS2[0];
			rS1 <= {2'h0, refClkIn}; rS2 <= rS1; rS3 <= rS2[0];
		end
	end

	logic tRise, rRise, rFall, refEdge, charStb;
	always_comb begin
		tRise = tS2[0] & ~tS3;
		rRise = rS2[0] & ~rS3;
		rFall = ~rS2[0] & rS3;
		refEdge = rRise | rFall;
		// zero picks the transmit input clock, else reference clock
		if (!cfg[CFG_CLKSEL])
			charStb = tRise;
		else if (cfg[CFG_HALF])
			charStb = refEdge;
		else
			charStb = rRise;
	end

	stx_capture u_cap (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.charStb (charStb),
		.charIn  (dS2),
		.ctrlIn  (cS2),
		.bypass  (cfg[CFG_BYPASS]),
		.out     (chr)
	);

	// write decode
	logic wrFire, wrOk, rdFire, cmdRecentre, cmdSync;
	logic [AXI_DW-1:0] rdVal;
	logic pdown, passPulse, passEnd;
	logic [CNT_W-1:0] passLen;
	logic [EV_W-1:0] ev;
	always_comb begin
		wrFire = awr & wr & ~bv;
		wrOk = mapped(awa);
		cmdRecentre = wrFire && awa == CMD_ADDR && wd[CMD_RECENTRE] && ws[0];
		cmdSync = wrFire && awa == CMD_ADDR && wd[CMD_SYNC] && ws[0];
		rdFire = arr & ~rv;
		pdown = ~cfg[CFG_OE1] & ~cfg[CFG_OE2];
		passLen = cfg[CFG_RXSEL] ? CNT_W'(PASS_LONG - 1)
			: CNT_W'(PASS_NORM - 1);
		// >= so a shorter pass picked mid-count still wraps
		passEnd = chr.valid && passCnt >= passLen;
		passPulse = passEnd && !cfg[CFG_BISTN];
		// phase buffer: char strobe while the previous symbol is still being sent and none is captured
		next_ovf = charStb & symV & ~chr.valid;
		// reference watchdog: no rising edge for REF_TMO cycles means absent
		next_refCnt = rRise ? '0 : refCnt;
		if (!rRise && refCnt != CNT_W'(REF_TMO))
			next_refCnt = refCnt + CNT_W'(1);
		next_refLost = (next_refCnt == CNT_W'(REF_TMO));
		ev = '0;
		ev[EV_BUFERR] = ovf;
		ev[EV_PASS] = passPulse;
		ev[EV_NOREF] = next_refLost & ~refLost;
		case (s_axi_araddr)
			CFG_ADDR:  rdVal = {{(AXI_DW-CFG_W){1'b0}}, cfg};
			STAT_ADDR: rdVal = {28'h0, refLost, pdown, bufErr, err};
			IRQS_ADDR: rdVal = {{(AXI_DW-EV_W){1'b0}}, irqs};
			IMSK_ADDR: rdVal = {{(AXI_DW-EV_W){1'b0}}, imsk};
			default:   rdVal = 32'h0;
		endcase
	end

	always_comb begin
		next_cfg = cfg;
		next_imsk = imsk;
		if (wrFire && ws[0] && awa == CFG_ADDR)
			next_cfg = wd[CFG_W-1:0];
		if (wrFire && ws[0] && awa == IMSK_ADDR)
			next_imsk = wd[EV_W-1:0];
		// read clears; a new event in the same cycle still lands
		next_irqs = irqs;
		if (rdFire && s_axi_araddr == IRQS_ADDR)
			next_irqs = '0;
		next_irqs = next_irqs | ev;
		// buffer error sticks until recentre or word sync sent
		next_bufErr = bufErr;
		next_syncPend = syncPend | cmdSync;
		if (syncPend && chr.valid) begin
			next_bufErr = 1'b0;
			next_syncPend = 1'b0;
		end
		if (cmdRecentre)
			next_bufErr = 1'b0;
		if (ovf)
			next_bufErr = 1'b1;
		next_passCnt = passCnt;
		if (cfg[CFG_BISTN])
			next_passCnt = '0;
		else if (chr.valid)
			next_passCnt = passEnd ? '0 : passCnt + CNT_W'(1);
		// error output priority: no ref, powered down, bist, buffer
		if (refLost)
			next_err = 1'b1;
		else if (pdown)
			next_err = 1'b1;
		else if (!cfg[CFG_BISTN])
			next_err = passPulse;
		else
			next_err = next_bufErr;
		next_sym = sym;
		next_kind = kind;
		next_symV = chr.valid ? 1'b1 : 1'b0;
		if (chr.valid) begin
			next_sym = chr.sym;
			if (chr.bypass)
				next_kind = STX_KIND_DATA;
			else begin
				case (chr.sym[SYM_W-1:CHAR_W])
					CT_DATA:    next_kind = STX_KIND_DATA;
					CT_SPECIAL: next_kind = STX_KIND_SPECIAL;
					CT_REPLACE: next_kind = STX_KIND_REPL;
					CT_ERRCHR:  next_kind = STX_KIND_REPL;
					default:    next_kind = STX_KIND_DATA;
				endcase
			end
		end
	end

	// axi slave: aw/w accepted in either order, response after both
	always_comb begin
		next_awr = awr;
		next_awa = awa;
		next_wr = wr;
		next_wd = wd;
		next_ws = ws;
		next_bv = bv;
		next_br = br;
		if (s_axi_awvalid && awRdy) begin
			next_awr = 1'b1;
			next_awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && wRdy) begin
			next_wr = 1'b1;
			next_wd = s_axi_wdata;
			next_ws = s_axi_wstrb;
		end
		if (wrFire) begin
			next_bv = 1'b1;
			next_br = wrOk ? RESP_OKAY : RESP_SLVERR;
		end
		if (bv && s_axi_bready) begin
			next_bv = 1'b0;
			next_awr = 1'b0;
			next_wr = 1'b0;
		end
		// ready comes from a flop: high while the holding slot is free
		next_awRdy = ~next_awr;
		next_wRdy = ~next_wr;
		next_arr = 1'b0;
		next_rv = rv;
		next_rr = rr;
		next_rd = rd;
		if (s_axi_arvalid && !rv && !arr)
			next_arr = 1'b1;
		if (rdFire && s_axi_arvalid) begin
			next_rv = 1'b1;
			next_rd = rdVal;
			next_rr = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rv && s_axi_rready)
			next_rv = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cfg <= CFG_RST; imsk <= '0; irqs <= '0;
			bufErr <= 1'b0; syncPend <= 1'b0; ovf <= 1'b0;
			passCnt <= '0; refCnt <= '0; refLost <= 1'b0;
			err <= 1'b0; sym <= '0; kind <= STX_KIND_DATA; symV <= 1'b0;
			awr <= 1'b0; awa <= '0; wr <= 1'b0; wd <= '0; ws <= '0;
			bv <= 1'b0; br <= RESP_OKAY; rv <= 1'b0; rr <= RESP_OKAY;
			rd <= '0; arr <= 1'b0; irq <= 1'b0;
			awRdy <= 1'b0; wRdy <= 1'b0;
		end else begin
			cfg <= next_cfg; imsk <= next_imsk; irqs <= next_irqs;
			bufErr <= next_bufErr; syncPend <= next_syncPend;
			ovf <= next_ovf; passCnt <= next_passCnt;
			refCnt <= next_refCnt; refLost <= next_refLost;
			err <= next_err; sym <= next_sym; kind <= next_kind;
			symV <= next_symV;
			awr <= next_awr; awa <= next_awa; wr <= next_wr;
			wd <= next_wd; ws <= next_ws; bv <= next_bv; br <= next_br;
			rv <= next_rv; rr <= next_rr; rd <= next_rd; arr <= next_arr;
			awRdy <= next_awRdy; wRdy <= next_wRdy;
			irq <= |(next_irqs & next_imsk);
		end
	end

	assign txErrorFlag = err;
	assign txSym = sym;
	assign txKind = kind;
	assign txSymValid = symV;
	assign s_axi_awready = awRdy;
	assign s_axi_wready = wRdy;
	assign s_axi_bvalid = bv;
	assign s_axi_bresp = br;
	assign s_axi_arready = arr;
	assign s_axi_rvalid = rv;
	assign s_axi_rresp = rr;
	assign s_axi_rdata = rd;

	pdown_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$past(pdown) && !$past(sys_rst) |-> err)
		else $error("error low while powered down");
	noref_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
		refLost |=> err)
		else $error("error low with reference absent");
	buferr_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
		ovf |=> bufErr)
		else $error("overflow did not set buffer error");
	buferr_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		bufErr && !cmdRecentre && !syncPend |=> bufErr)
		else $error("buffer error dropped early");
	recentre_clr_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cmdRecentre && !ovf |=> !bufErr)
		else $error("recentre did not clear buffer error");
	bist_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
		passPulse && !refLost && !pdown |=> err ##1 !err)
		else $error("bist pulse not one cycle");
	pass_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
		passCnt <= CNT_W'(PASS_LONG - 1))
		else $error("pass counter overran");
	bist_mask_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!cfg[CFG_BISTN] && !passPulse && !refLost && !pdown
		&& $stable(cfg) |=> !err)
		else $error("buffer error shown during self-test");
endmodule // stx_tx_port

// *** stx_host_model.sv ***
// stx_host_model: host logic driving characters and clocks into the port
// assumes: mclk from the bench; all timing counted in mclk cycles
`timescale 1ns/1ps
module stx_host_model
	import stx_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         refOn,
	output logic              txInputClk,
	output logic [CHAR_W-1:0] txCharIn,
	output logic [CTRL_W-1:0] txCtrlFieldIn,
	output logic              refClkIn
);
	logic [1:0] refDiv = 2'h0;
	initial begin
		txInputClk = 1'b0;
		txCharIn = '0;
		txCtrlFieldIn = '0;
		refClkIn = 1'b0;
	end
	// oscillator stops dead to mimic a lost reference
	always @(posedge mclk) begin
		refDiv <= refDiv + 2'h1;
		if (!refOn)
			refClkIn <= 1'b0;
		else if (refDiv == 2'h3)
			refClkIn <= ~refClkIn;
	end
	// clock toggling every cycle gives strobes two cycles apart,
	// closer than the phase buffer can drain
	task automatic race(input int n);
		repeat (n) begin
			txInputClk <= 1'b1;
			@(posedge mclk);
			txInputClk <= 1'b0;
			@(posedge mclk);
		end
	endtask
	// half of at least 4 keeps the pins inside the hold window
	task automatic send(input logic [CHAR_W-1:0] c,
		input logic [CTRL_W-1:0] t, input int half);
		txCharIn <= c;
		txCtrlFieldIn <= t;
		repeat (half) @(posedge mclk);
		txInputClk <= 1'b1;
		repeat (half) @(posedge mclk);
		txInputClk <= 1'b0;
		repeat (half) @(posedge mclk);
		// released pins must not look like held data
		txCharIn <= ~c;
		txCtrlFieldIn <= ~t;
	endtask
endmodule // stx_host_model

// *** serdes_tx_char_input_port_tb_top.sv ***
// serdes_tx_char_input_port_tb_top: self-checking bench for stx_tx_port
// assumes: host model drives pins; bench is the AXI4-Lite master
`timescale 1ns/1ps
module serdes_tx_char_input_port_tb_top;
	import stx_pkg::*;
	localparam int TMO = 8;
	logic              mclk, sys_rst, refOn, txInputClk, refClkIn;
	logic              txErrorFlag, txSymValid, irq, errQ;
	logic [CHAR_W-1:0] txCharIn;
	logic [CTRL_W-1:0] txCtrlFieldIn;
	logic [SYM_W-1:0]  txSym, lastSym;
	logic [2:0]        txKind, lastKind;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic [AXI_DW-1:0] wdata, rdata, rd;
	logic [1:0]        bresp, rresp, rsp;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	int mismatches, tests_run, symCount, markCnt, passLen, rises, wide, d;
	stx_tx_port #(.REF_TMO(TMO)) u_stx_tx_port (.mclk(mclk),
		.sys_rst(sys_rst), .txCharIn(txCharIn),
		.txCtrlFieldIn(txCtrlFieldIn), .txInputClk(txInputClk),
		.refClkIn(refClkIn), .txErrorFlag(txErrorFlag), .txSym(txSym),
		.txKind(txKind), .txSymValid(txSymValid), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	stx_host_model u_stx_host_model (.mclk(mclk), .refOn(refOn),
		.txInputClk(txInputClk), .txCharIn(txCharIn),
		.txCtrlFieldIn(txCtrlFieldIn), .refClkIn(refClkIn));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		errQ <= txErrorFlag;
		if (txSymValid === 1'b1) begin
			symCount <= symCount + 1;
			lastSym <= txSym;
			lastKind <= txKind;
		end
		if (txErrorFlag === 1'b1 && errQ !== 1'b1) begin
			passLen <= symCount - markCnt;
			markCnt <= symCount;
			rises <= rises + 1;
			wide <= 1;
		end else if (txErrorFlag === 1'b1)
			wide <= wide + 1;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg,
				got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ready and answers sampled just before the edge that takes them
	task automatic axi(input logic wr, input logic [7:0] a,
		input logic [31:0] v);
		logic aGo, wGo, done;
		int n;
		if (wr) begin
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		done = 1'b0;
		n = 0;
		while (!done && n < 200) begin
			@(negedge mclk);
			aGo = wr ? awvalid & awready : arvalid & arready;
			wGo = wvalid & wready;
			done = wr ? bvalid & bready : rvalid & rready;
			rsp = wr ? bresp : rresp;
			rd = rdata;
			@(posedge mclk);
			if (aGo && wr) awvalid <= 1'b0;
			if (aGo && !wr) arvalid <= 1'b0;
			if (wGo) wvalid <= 1'b0;
			if (done && wr) bready <= 1'b0;
			if (done && !wr) rready <= 1'b0;
			n++;
		end
		// one idle edge so the next call never re-raises a released line
		@(posedge mclk);
		check(done, 1'b1, "bus answer");
	endtask
	task automatic sendChk(input logic [7:0] c, input logic [1:0] t,
		input logic [2:0] k);
		int n;
		d = symCount;
		u_stx_host_model.send(c, t, 4);
		for (n = 0; n < 40 && symCount == d; n++) @(posedge mclk);
		@(posedge mclk);
		check(symCount != d, 1, "symbol seen");
		check(lastSym, {t, c}, "symbol");
		check(lastKind, k, "kind");
	endtask
	task automatic waitRises(input int k);
		int n;
		d = rises;
		for (n = 0; n < 20000 && rises < d + k; n++) @(posedge mclk);
		check(rises >= d + k, 1, "pulses seen");
	endtask
	initial begin
		repeat (80000) @(posedge mclk);
		mismatches++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		summarize();
	end
	initial begin
		{sys_rst, refOn, awvalid, wvalid, bready, arvalid, rready} = 7'h60;
		{awaddr, araddr, wdata} = '0;
		{symCount, markCnt, passLen, rises, wide} = '0;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		axi(0, CFG_ADDR, 0);
		check(rd, {25'h0, CFG_RST}, "cfg reset");
		axi(0, STAT_ADDR, 0);
		check(rd, 0, "status reset");
		axi(0, LAST_ADDR, 0);
		check(rsp, RESP_SLVERR, "unmapped read");
		check(rd, 0, "unmapped data");
		axi(1, 8'h18, 1);
		check(rsp, RESP_SLVERR, "unmapped write");
		$display("test registers done");
		sendChk(8'ha5, CT_DATA, STX_KIND_DATA);
		sendChk(8'h5a, CT_SPECIAL, STX_KIND_SPECIAL);
		sendChk(8'hc3, CT_REPLACE, STX_KIND_REPL);
		sendChk(8'h3c, CT_ERRCHR, STX_KIND_REPL);
		axi(1, CFG_ADDR, 32'h36);
		sendChk(8'h81, 2'h2, STX_KIND_DATA);
		$display("test capture done");
		axi(1, CFG_ADDR, 32'h34);
		d = symCount;
		repeat (80) @(posedge mclk);
		check(symCount - d, 0, "ref ignored");
		axi(1, CFG_ADDR, 32'h35);
		d = symCount;
		repeat (80) @(posedge mclk);
		check(symCount - d inside {[9:11]}, 1, "ref rising");
		axi(1, CFG_ADDR, 32'h75);
		d = symCount;
		repeat (80) @(posedge mclk);
		check(symCount - d inside {[19:21]}, 1, "half rate");
		$display("test clock source done");
		axi(1, CFG_ADDR, 32'h04);
		repeat (4) @(posedge mclk);
		check(txErrorFlag, 1'b1, "pdown error");
		axi(0, STAT_ADDR, 0);
		check(rd & 32'h4, 32'h4, "pdown status");
		axi(1, CFG_ADDR, 32'h34);
		repeat (4) @(posedge mclk);
		check(txErrorFlag, 1'b0, "power up");
		axi(1, IMSK_ADDR, 0);
		refOn <= 1'b0;
		repeat (TMO + 20) @(posedge mclk);
		check(txErrorFlag, 1'b1, "ref lost");
		check(irq, 1'b0, "irq masked");
		axi(1, IMSK_ADDR, 32'h4);
		repeat (2) @(posedge mclk);
		check(irq, 1'b1, "irq raised");
		axi(0, STAT_ADDR, 0);
		check(rd & 32'h8, 32'h8, "ref status");
		refOn <= 1'b1;
		repeat (TMO + 20) @(posedge mclk);
		check(txErrorFlag, 1'b0, "ref back");
		axi(0, IRQS_ADDR, 0);
		check(rd & 32'h4, 32'h4, "noref event");
		axi(0, IRQS_ADDR, 0);
		check(rd & 32'h4, 0, "read clears");
		check(irq, 1'b0, "irq cleared");
		$display("test error sources done");
		u_stx_host_model.race(3);
		repeat (8) @(posedge mclk);
		check(txErrorFlag, 1'b1, "buffer error");
		axi(0, STAT_ADDR, 0);
		check(rd & 32'h2, 32'h2, "buffer status");
		u_stx_host_model.send(8'h22, 2'h0, 4);
		check(txErrorFlag, 1'b1, "error held");
		axi(1, CMD_ADDR, 32'h1);
		repeat (4) @(posedge mclk);
		check(txErrorFlag, 1'b0, "recentred");
		u_stx_host_model.race(3);
		repeat (8) @(posedge mclk);
		check(txErrorFlag, 1'b1, "error again");
		axi(1, CMD_ADDR, 32'h2);
		u_stx_host_model.send(8'h44, 2'h0, 4);
		repeat (8) @(posedge mclk);
		check(txErrorFlag, 1'b0, "sync sent");
		axi(0, IRQS_ADDR, 0);
		check(rd & 32'h1, 32'h1, "buffer event");
		$display("test buffer error done");
		axi(1, CFG_ADDR, 32'h31);
		waitRises(3);
		check(passLen, PASS_NORM, "short pass");
		repeat (4) @(posedge mclk);
		check(wide, 1, "pulse width");
		axi(1, CFG_ADDR, 32'h39);
		waitRises(3);
		check(passLen, PASS_LONG, "long pass");
		axi(0, IRQS_ADDR, 0);
		check(rd & 32'h2, 32'h2, "pass event");
		$display("test self-test done");
		summarize();
	end
endmodule // serdes_tx_char_input_port_tb_top
